// ===== logic/aor_routing_reg.sv
// analog output routing register with plain register port
//
// Chosen here: the register offset and the address-and-strobe port.
`timescale 1ns/100ps
`include "aor_defines.svh"
module aor_routing_reg
  import aor_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic sidetone_to_headset_sel_out,
  output logic sidetone_to_handset_sel_out,
  output logic dac_to_speaker_sel_out,
  output logic dac_to_line_driver_sel_out,
  output logic dac_to_handset_sel_out,
  output logic dac_to_headset_sel_out
);
  //----------------------------------------------------------------
  // register state
  //----------------------------------------------------------------
  aor_route_t route_reg;
  aor_route_t route_next;
  aor_byte_t rdata_reg;
  aor_byte_t rdata_next;
  aor_byte_t wmask;
  logic addr_hit;
  logic wr_hit;
  logic rd_hit;
  logic rd_miss;

  //----------------------------------------------------------------
  // address decode
  //----------------------------------------------------------------
  assign addr_hit = (addr_in == `AOR_OFFSET);
  assign wr_hit = wr_in && addr_hit;
  assign rd_hit = rd_in && addr_hit;
  assign rd_miss = rd_in && !addr_hit;

  //----------------------------------------------------------------
  // next state
  //----------------------------------------------------------------
  always_comb begin
    wmask = `AOR_ROUTE_MASK;
    route_next = route_reg;
    rdata_next = 8'h00;
    if (wr_in && addr_in == `AOR_OFFSET) begin
      route_next = aor_route_t'(wdata_in & wmask); // R1 R2 R3 R4 R5 R6
    end
    if (rd_in) begin
      if (addr_in == `AOR_OFFSET) begin
        rdata_next = `AOR_SELECT_BIT | {2'h0, route_reg}; // R7
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      route_reg <= aor_route_t'(`AOR_RESET_VALUE); // R1 R2 R3 R4 R5 R6
      rdata_reg <= 8'h00;
    end else if (clk_en_in) begin
      route_reg <= route_next;
      rdata_reg <= rdata_next;
    end
  end

  //----------------------------------------------------------------
  // read data and switch enables
  //----------------------------------------------------------------
  assign rdata_out = rdata_reg;
  assign sidetone_to_headset_sel_out = route_reg[`AOR_BIT_SIDETONE_HEADSET]; // R1
  assign sidetone_to_handset_sel_out = route_reg[`AOR_BIT_SIDETONE_HANDSET]; // R2
  assign dac_to_speaker_sel_out = route_reg[`AOR_BIT_SPEAKER]; // R3
  assign dac_to_line_driver_sel_out = route_reg[`AOR_BIT_LINE]; // R4
  assign dac_to_handset_sel_out = route_reg[`AOR_BIT_HANDSET]; // R5
  assign dac_to_headset_sel_out = route_reg[`AOR_BIT_HEADSET]; // R6

  //----------------------------------------------------------------
  // write path checks
  //----------------------------------------------------------------
  a_sthd_write: assert property ( // R1
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && wr_hit |=>
    sidetone_to_headset_sel_out == $past(wdata_in[5]))
    else $error("sidetone headset bit not written");

  a_sthn_write: assert property ( // R2
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && wr_hit |=>
    sidetone_to_handset_sel_out == $past(wdata_in[4]))
    else $error("sidetone handset bit not written");

  a_spk_write: assert property ( // R3
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && wr_hit |=>
    dac_to_speaker_sel_out == $past(wdata_in[3]))
    else $error("speaker bit not written");

  a_line_write: assert property ( // R4
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && wr_hit |=>
    dac_to_line_driver_sel_out == $past(wdata_in[2]))
    else $error("line bit not written");

  a_hns_write: assert property ( // R5
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && wr_hit |=>
    dac_to_handset_sel_out == $past(wdata_in[1]))
    else $error("handset bit not written");

  a_hds_write: assert property ( // R6
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && wr_hit |=>
    dac_to_headset_sel_out == $past(wdata_in[0]))
    else $error("headset bit not written");

  a_unmapped_write_hold: assert property ( // R1 R2 R3 R4 R5 R6
    @(posedge mclk_in) disable iff (rst_in)
    wr_in && !addr_hit |=>
    $stable(route_reg))
    else $error("routing changed by unmapped write");

  a_freeze_write_hold: assert property ( // R1 R2 R3 R4 R5 R6
    @(posedge mclk_in) disable iff (rst_in)
    !clk_en_in && wr_hit |=>
    $stable(route_reg))
    else $error("routing changed while frozen");

  //----------------------------------------------------------------
  // read path checks
  //----------------------------------------------------------------
  a_read_fixed: assert property ( // R7
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && rd_hit |=>
    rdata_out[7:6] == 2'h2)
    else $error("fixed bits wrong on read");

  a_read_route: assert property ( // R7
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && rd_hit && !wr_in |=>
    rdata_out[5:0] == $past(route_reg))
    else $error("read data does not match routing");

  a_reserved_zero: assert property ( // R7
    @(posedge mclk_in) disable iff (rst_in)
    1'b1 |->
    rdata_out[6] == 1'b0)
    else $error("reserved bit read as one");

  a_unmapped_read_zero: assert property ( // R7
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && rd_miss |=>
    rdata_out == 8'h00)
    else $error("unmapped read not zero");

  a_idle_read_zero: assert property ( // R7
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && !rd_in |=>
    rdata_out == 8'h00)
    else $error("read data not cleared when idle");

  a_read_one_cycle: assert property ( // R7
    @(posedge mclk_in) disable iff (rst_in)
    clk_en_in && rd_hit ##1 clk_en_in && !rd_in |=>
    rdata_out == 8'h00)
    else $error("read data stood too long");

  //----------------------------------------------------------------
  // reset and hold checks
  //----------------------------------------------------------------
  a_reset_clear: assert property ( // R1 R2 R3 R4 R5 R6
    @(posedge mclk_in)
    rst_in |=>
    route_reg == 6'h00)
    else $error("routing not cleared by reset");

  a_reset_rdata: assert property ( // R7
    @(posedge mclk_in)
    rst_in |=>
    rdata_out == 8'h00)
    else $error("read data not cleared by reset");

  a_hold_value: assert property ( // R1 R2 R3 R4 R5 R6
    @(posedge mclk_in) disable iff (rst_in)
    !(clk_en_in && wr_hit) |=>
    $stable(route_reg))
    else $error("routing changed without write");

  a_freeze_hold: assert property ( // R7
    @(posedge mclk_in) disable iff (rst_in)
    !clk_en_in |=>
    $stable(rdata_out) && $stable(route_reg))
    else $error("state changed while frozen");

  //----------------------------------------------------------------
  // scenario covers
  //----------------------------------------------------------------
  c_write: cover property (
    @(posedge mclk_in) clk_en_in && wr_hit);
  c_read: cover property (
    @(posedge mclk_in) clk_en_in && rd_hit);
  c_all_on: cover property (
    @(posedge mclk_in) route_reg == 6'h3F);
  c_unmapped_read: cover property (
    @(posedge mclk_in) clk_en_in && rd_miss);
  c_frozen_write: cover property (
    @(posedge mclk_in) !clk_en_in && wr_hit);
endmodule // aor_routing_reg

// ===== include/aor_defines.svh
// constants for the analog output routing register
`ifndef AOR_DEFINES_SVH
`define AOR_DEFINES_SVH
//----------------------------------------------------------------
// Overview of operation
// (R1) bit 5 routes sidetone to headset, reset 0
// (R2) bit 4 routes sidetone to handset, reset 0
// (R3) bit 3 routes dac to speaker, reset 0
// (R4) bit 2 routes dac to line driver, reset 0
// (R5) bit 1 routes dac to handset, reset 0
// (R6) bit 0 routes dac to headset, reset 0
// (R7) bit 6 reads zero, bit 7 fixed one
//----------------------------------------------------------------
`define AOR_OFFSET 8'h00
`define AOR_BIT_SIDETONE_HEADSET 5
`define AOR_BIT_SIDETONE_HANDSET 4
`define AOR_BIT_SPEAKER 3
`define AOR_BIT_LINE 2
`define AOR_BIT_HANDSET 1
`define AOR_BIT_HEADSET 0
`define AOR_ROUTE_MASK 8'h3F
`define AOR_SELECT_BIT 8'h80
`define AOR_RESET_VALUE 8'h00
`endif

// ===== include/aor_pkg.sv
// types for the analog output routing register
package aor_pkg;
  typedef logic [7:0] aor_byte_t;
  typedef logic [5:0] aor_route_t;
endpackage

// ===== tb/aor_routing_reg_tb.sv
// testbench for the analog output routing register
`timescale 1ns/100ps
`include "aor_defines.svh"
module aor_routing_reg_tb;
  import aor_pkg::*;
  logic mclk_in = 0, rst_in = 1, clk_en_in = 1, wr_in = 0, rd_in = 0;
  aor_byte_t addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  wire logic [5:0] sel;
  int miscompares = 0, num_checks = 0, cycles = 0;
  always #2 mclk_in = ~mclk_in;
  aor_routing_reg uut (.mclk_in(mclk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .sidetone_to_headset_sel_out(sel[5]), .sidetone_to_handset_sel_out(sel[4]),
    .dac_to_speaker_sel_out(sel[3]), .dac_to_line_driver_sel_out(sel[2]),
    .dac_to_handset_sel_out(sel[1]), .dac_to_headset_sel_out(sel[0]));
  //--------------------------------
  // bus tasks
  //--------------------------------
  task automatic chk(input aor_byte_t got, input aor_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input aor_byte_t a, input aor_byte_t d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input aor_byte_t a, input aor_byte_t exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
    @(posedge mclk_in);
    #1 chk(rdata_out, 8'h00);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end
  //--------------------------------
  // tests
  //--------------------------------
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1 chk({2'b00, sel}, `AOR_RESET_VALUE);
    rd(`AOR_OFFSET, `AOR_SELECT_BIT);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      wr(`AOR_OFFSET, 8'hC0 | (8'h01 << i));
      chk({2'b00, sel}, 8'h01 << i);
      rd(`AOR_OFFSET, 8'h80 | (8'h01 << i));
    end
    $display("walking bit test done");
    wr(8'h01, 8'h3F);
    chk({2'b00, sel}, 8'h20);
    rd(8'h01, 8'h00);
    clk_en_in <= 1'b0;
    wr(`AOR_OFFSET, 8'h1F);
    chk({2'b00, sel}, 8'h20);
    clk_en_in <= 1'b1;
    wr(`AOR_OFFSET, 8'h3F);
    rd(`AOR_OFFSET, 8'hBF);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    @(posedge mclk_in);
    rst_in <= 1'b0;
    #1 chk({2'b00, sel}, 8'h00);
    $display("refusal and reset test done");
    conclude();
  end
endmodule // aor_routing_reg_tb
